//--- shared/qei_pkg.sv
package qei_pkg;

    // ------------------------------------------------------------
    // widths and register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;

    localparam logic [5:0] OFS_CTRL     = 6'h00;
    localparam logic [5:0] OFS_STATUS   = 6'h04;
    localparam logic [5:0] OFS_POS      = 6'h08;
    localparam logic [5:0] OFS_MAXPOS   = 6'h0C;
    localparam logic [5:0] OFS_LOAD     = 6'h10;
    localparam logic [5:0] OFS_TIMER    = 6'h14;
    localparam logic [5:0] OFS_VEL      = 6'h18;
    localparam logic [5:0] OFS_COUNT    = 6'h1C;
    localparam logic [5:0] OFS_INTEN    = 6'h20;
    localparam logic [5:0] OFS_RIS      = 6'h24;
    localparam logic [5:0] OFS_ISC      = 6'h28;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int unsigned CTRL_ENABLE   = 0;
    localparam int unsigned CTRL_BOTH     = 1;
    localparam int unsigned CTRL_RESIDX   = 2;
    localparam int unsigned CTRL_CLKDIR   = 3;
    localparam int unsigned CTRL_SWAP     = 4;
    localparam int unsigned CTRL_VELEN    = 5;
    localparam int unsigned CTRL_W        = 6;
    localparam logic [5:0]  CTRL_RESET    = 6'h00;

    // status fields
    localparam int unsigned STAT_ERROR    = 0;
    localparam int unsigned STAT_DIR      = 1;

    // event bit order
    localparam int unsigned EV_INDEX      = 0;
    localparam int unsigned EV_TIMER      = 1;
    localparam int unsigned EV_DIR        = 2;
    localparam int unsigned EV_ERROR      = 3;
    localparam int unsigned EV_W          = 4;

    localparam logic [31:0] MAXPOS_RESET  = 32'hFFFF_FFFF;
    localparam logic [31:0] LOAD_RESET    = 32'h0000_0000;
    localparam logic [31:0] ZERO32        = 32'h0000_0000;
    localparam logic [31:0] ONE32         = 32'h0000_0001;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [5:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } qei_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } qei_wb_rsp_t;

    // one sample of decoded encoder motion
    typedef struct packed {
        logic step;     // a counted edge
        logic fwd;      // direction of that edge
        logic err;      // both phases moved together
    } qei_step_t;

endpackage

//--- hdl/qei_decode.sv
`timescale 1ns/100ps
`default_nettype none

module qei_decode (
    // clock and reset
    input  wire logic           ref_clk,
    input  wire logic           reset_n,
    input  wire logic           clk_en,
    // configuration
    input  wire logic           swap,
    input  wire logic           clk_dir_mode,
    input  wire logic           count_both,
    // encoder pins
    input  wire logic           encoder_input_first,
    input  wire logic           encoder_input_second,
    // decoded motion
    output qei_pkg::qei_step_t  step
);

    typedef struct packed {
        logic a;
        logic b;
        qei_pkg::qei_step_t st;
    } qei_dec_state_t;

    qei_dec_state_t s_q;
    qei_dec_state_t s_d;
    logic           a_in;
    logic           b_in;
    logic           a_chg;
    logic           b_chg;

    // channel swap ahead of all decoding
    assign a_in  = swap ? encoder_input_second : encoder_input_first;
    assign b_in  = swap ? encoder_input_first : encoder_input_second;
    assign a_chg = a_in ^ s_q.a;
    assign b_chg = b_in ^ s_q.b;

    // edge classification; pins are taken as already synchronous
    always_comb begin
        s_d         = s_q;
        s_d.a       = a_in;
        s_d.b       = b_in;
        s_d.st      = '0;
        if (clk_dir_mode) begin
            // step on either edge of the step input, level gives direction
            s_d.st.step = a_chg;
            s_d.st.fwd  = ~b_in;
        end else if (a_chg && b_chg) begin
            s_d.st.err  = 1'b1;
        end else begin
            // forward when a leads b: new a differs from old b
            if (a_chg) begin
                s_d.st.step = 1'b1;
                s_d.st.fwd  = a_in ^ s_q.b;
            end else if (b_chg && count_both) begin
                s_d.st.step = 1'b1;
                s_d.st.fwd  = ~(b_in ^ s_q.a);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign step = s_q.st;

    phase_err_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && !clk_dir_mode && a_chg && b_chg) |=> (step.err && !step.step))
        else $error("double phase change not flagged");

endmodule
`default_nettype wire

//--- hdl/qei_velocity.sv
`timescale 1ns/100ps
`default_nettype none

module qei_velocity #(
    parameter int unsigned CNT_W = 32
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    // control
    input  wire logic             run,
    input  wire logic [CNT_W-1:0] load,
    input  wire logic             pulse,
    // results
    output logic [CNT_W-1:0]      timer,
    output logic [CNT_W-1:0]      running,
    output logic [CNT_W-1:0]      final_cnt,
    output logic                  expired
);

    // widths beyond one bus word or below two bits break the read mux
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
        $error("velocity width out of range");
    end

    typedef struct packed {
        logic [CNT_W-1:0] tmr;
        logic [CNT_W-1:0] acc;
        logic [CNT_W-1:0] fin;
        logic             exp;
    } qei_vel_state_t;

    qei_vel_state_t s_q;
    qei_vel_state_t s_d;

    // timer counts down to zero, then reloads and latches the total
    always_comb begin
        s_d     = s_q;
        s_d.exp = 1'b0;
        if (!run) begin
            // parked while disabled so a fresh period starts clean
            s_d.tmr = load;
            s_d.acc = '0;
        end else if (s_q.tmr == '0) begin
            s_d.tmr = load;
            s_d.fin = s_q.acc + CNT_W'(pulse);
            s_d.acc = '0;
            s_d.exp = 1'b1;
        end else begin
            s_d.tmr = s_q.tmr - CNT_W'(1);
            s_d.acc = s_q.acc + CNT_W'(pulse);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign timer     = s_q.tmr;
    assign running   = s_q.acc;
    assign final_cnt = s_q.fin;
    assign expired   = s_q.exp;

    vel_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && !run) |=> (running == '0 && !expired))
        else $error("velocity ran while disabled");

    vel_latch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && run && timer == '0) |=> (expired && final_cnt == $past(running) + CNT_W'($past(pulse))))
        else $error("final count not latched");

endmodule
`default_nettype wire

//--- hdl/qei_top.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - phase mode decodes two quadrature inputs and takes direction from which edge leads.
// - clock/direction mode counts each step edge and takes direction from the direction level.
// - in phase mode a setting counts edges of the first channel only or of both channels.
// - a swap setting exchanges the two inputs before any decoding.
// - with index reset enabled an index pulse resets the position counter.
// - with index reset disabled the index pulse never touches the position counter.
// - a velocity timer marks equal periods and pulses are accumulated within each period.
// - software reads the running pulse total and the count latched at the previous period end.
// - velocity timer and accumulator run only while position capture is enabled.
// - separate flags rise on index, timer expiry, direction change and phase error.
// - each event has a mask bit and only unmasked events drive the interrupt output.
// - in phase mode a phase error is flagged when both inputs change together and a readable error bit is kept.
// - a maximum position bounds the counter and index reset in reverse loads that maximum.
// - direction status holds the last detected direction after motion stops.
// - a software clear drops the selected flags until the event recurs.
module qei_top (
    // clock, reset, enable
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    // wishbone slave
    input  wire qei_pkg::qei_wb_req_t wb_req,
    output qei_pkg::qei_wb_rsp_t     wb_rsp,
    // encoder pins
    input  wire logic                encoder_input_first,
    input  wire logic                encoder_input_second,
    input  wire logic                index_in,
    // interrupt
    output logic                     irq
);

    typedef struct packed {
        logic [qei_pkg::CTRL_W-1:0] ctrl;
        logic [31:0]                pos;
        logic [31:0]                maxpos;
        logic [31:0]                load;
        logic [qei_pkg::EV_W-1:0]   inten;
        logic [qei_pkg::EV_W-1:0]   ris;
        logic                       err;
        logic                       dir;
        logic                       idx_prev;
        logic                       ack;
        logic [31:0]                rdat;
    } qei_state_t;

    qei_state_t         s_q;
    qei_state_t         s_d;
    qei_pkg::qei_step_t step;
    logic [31:0]        vel_timer;
    logic [31:0]        vel_running;
    logic [31:0]        vel_final;
    logic               vel_expired;
    logic               pos_en;
    logic               access;
    logic               wr;
    logic               idx_rise;
    logic [qei_pkg::EV_W-1:0] ev_set;
    logic [qei_pkg::EV_W-1:0] ev_clr;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    qei_decode u_decode (
        .ref_clk              (ref_clk),
        .reset_n              (reset_n),
        .clk_en               (clk_en),
        .swap                 (s_q.ctrl[qei_pkg::CTRL_SWAP]),
        .clk_dir_mode         (s_q.ctrl[qei_pkg::CTRL_CLKDIR]),
        .count_both           (s_q.ctrl[qei_pkg::CTRL_BOTH]),
        .encoder_input_first  (encoder_input_first),
        .encoder_input_second (encoder_input_second),
        .step                 (step)
    );

    qei_velocity #(
        .CNT_W (32)
    ) u_velocity (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .run       (pos_en && s_q.ctrl[qei_pkg::CTRL_VELEN]),
        .load      (s_q.load),
        .pulse     (step.step),
        .timer     (vel_timer),
        .running   (vel_running),
        .final_cnt (vel_final),
        .expired   (vel_expired)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // merge write data into an old word by byte lanes
    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // step the counter with wrap between zero and maximum
    // a count already above a lowered maximum rolls to zero on the next forward step
    function automatic logic [31:0] pos_step(input logic [31:0] p, input logic fwd,
                                             input logic [31:0] mx);
        logic [31:0] r;
        r = p;
        if (fwd) begin
            r = (p >= mx) ? qei_pkg::ZERO32 : p + qei_pkg::ONE32;
        end else begin
            r = (p == qei_pkg::ZERO32) ? mx : p - qei_pkg::ONE32;
        end
        return r;
    endfunction

    assign pos_en   = s_q.ctrl[qei_pkg::CTRL_ENABLE];
    assign access   = wb_req.cyc && wb_req.stb && !s_q.ack;
    // writes land at the acking edge, while the master still holds the request
    assign wr       = wb_req.cyc && wb_req.stb && wb_req.we && s_q.ack;
    assign idx_rise = index_in && !s_q.idx_prev;

    // event sources gathered in flag order
    always_comb begin
        // events only while position capture runs, so a parked encoder stays quiet
        ev_set                    = '0;
        ev_set[qei_pkg::EV_INDEX] = pos_en && idx_rise;
        ev_set[qei_pkg::EV_TIMER] = vel_expired;
        ev_set[qei_pkg::EV_DIR]   = pos_en && step.step && (step.fwd != s_q.dir);
        ev_set[qei_pkg::EV_ERROR] = pos_en && step.err;
        ev_clr                    = '0;
        if (wr && wb_req.adr == qei_pkg::OFS_ISC) begin
            ev_clr = wb_req.dat[qei_pkg::EV_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // next state: position, flags, registers, bus answer
    // ------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.ack      = access;
        s_d.idx_prev = index_in;
        // set wins over a clear in the same cycle
        s_d.ris      = (s_q.ris & ~ev_clr) | ev_set;

        if (pos_en) begin
            if (step.err) begin
                s_d.err = 1'b1;
            end
            if (step.step) begin
                s_d.dir = step.fwd;
                s_d.pos = pos_step(s_q.pos, step.fwd, s_q.maxpos);
            end
            if (idx_rise && s_q.ctrl[qei_pkg::CTRL_RESIDX]) begin
                // reverse travel lands on the top of the range
                s_d.pos = s_q.dir ? qei_pkg::ZERO32 : s_q.maxpos;
            end
        end

        // register writes; position write yields to nothing since software owns it
        if (wr) begin
            unique case (wb_req.adr)
                qei_pkg::OFS_CTRL: begin
                    s_d.ctrl = (qei_pkg::CTRL_W)'(wb_merge({26'h0, s_q.ctrl}, wb_req.dat,
                                        wb_req.sel));
                end
                qei_pkg::OFS_STATUS: begin
                    if (wb_req.dat[qei_pkg::STAT_ERROR] && !step.err) begin
                        s_d.err = 1'b0;
                    end
                end
                qei_pkg::OFS_POS:    s_d.pos    = wb_merge(s_q.pos, wb_req.dat, wb_req.sel);
                qei_pkg::OFS_MAXPOS: s_d.maxpos = wb_merge(s_q.maxpos, wb_req.dat, wb_req.sel);
                qei_pkg::OFS_LOAD:   s_d.load   = wb_merge(s_q.load, wb_req.dat, wb_req.sel);
                qei_pkg::OFS_INTEN: begin
                    s_d.inten = (qei_pkg::EV_W)'(wb_merge({28'h0, s_q.inten}, wb_req.dat,
                                         wb_req.sel));
                end
                default: begin
                end
            endcase
        end

        // read mux; unmapped offsets read zero
        s_d.rdat = qei_pkg::ZERO32;
        if (access && !wb_req.we) begin
            unique case (wb_req.adr)
                qei_pkg::OFS_CTRL:   s_d.rdat = {26'h0, s_q.ctrl};
                qei_pkg::OFS_STATUS: s_d.rdat = {30'h0, s_q.dir, s_q.err};
                qei_pkg::OFS_POS:    s_d.rdat = s_q.pos;
                qei_pkg::OFS_MAXPOS: s_d.rdat = s_q.maxpos;
                qei_pkg::OFS_LOAD:   s_d.rdat = s_q.load;
                qei_pkg::OFS_TIMER:  s_d.rdat = vel_timer;
                qei_pkg::OFS_VEL:    s_d.rdat = vel_final;
                qei_pkg::OFS_COUNT:  s_d.rdat = vel_running;
                qei_pkg::OFS_INTEN:  s_d.rdat = {28'h0, s_q.inten};
                qei_pkg::OFS_RIS:    s_d.rdat = {28'h0, s_q.ris};
                qei_pkg::OFS_ISC:    s_d.rdat = {28'h0, s_q.ris & s_q.inten};
                default:             s_d.rdat = qei_pkg::ZERO32;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            s_q        <= '0;
            s_q.ctrl   <= qei_pkg::CTRL_RESET;
            s_q.maxpos <= qei_pkg::MAXPOS_RESET;
            s_q.load   <= qei_pkg::LOAD_RESET;
            // direction reads forward until the first counted step
            s_q.dir    <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_rsp.ack = s_q.ack;
    assign wb_rsp.dat = s_q.rdat;
    assign irq        = |(s_q.ris & s_q.inten);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    irq_mask_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && |(ev_set & s_q.inten) && !wr) |=> irq)
        else $error("unmasked event did not raise interrupt");

    idx_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && pos_en && idx_rise && s_q.ctrl[qei_pkg::CTRL_RESIDX] && s_q.dir && !wr)
        |=> s_q.pos == qei_pkg::ZERO32)
        else $error("index did not reset position");

    idx_rev_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && pos_en && idx_rise && s_q.ctrl[qei_pkg::CTRL_RESIDX] && !s_q.dir && !wr)
        |=> s_q.pos == $past(s_q.maxpos))
        else $error("reverse index did not load maximum");

    idx_rel_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && !s_q.ctrl[qei_pkg::CTRL_RESIDX] && !step.step && !wr)
        |=> $stable(s_q.pos))
        else $error("position moved without a step");

    pos_wrap_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && pos_en && step.step && step.fwd && s_q.pos == s_q.maxpos && !idx_rise && !wr)
        |=> s_q.pos == qei_pkg::ZERO32)
        else $error("forward wrap wrong");

    dir_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && !step.step) |=> $stable(s_q.dir))
        else $error("direction changed without motion");

    set_wins_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && ev_set[qei_pkg::EV_TIMER]) |=> s_q.ris[qei_pkg::EV_TIMER])
        else $error("timer event lost");

    err_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && pos_en && step.err) |=> (s_q.err && s_q.ris[qei_pkg::EV_ERROR]))
        else $error("phase error not recorded");

    step_dir_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && pos_en && step.step) |=> s_q.dir == $past(step.fwd))
        else $error("direction not taken from step");

    idx_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && pos_en && idx_rise) |=> s_q.ris[qei_pkg::EV_INDEX])
        else $error("index event lost");

    flag_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && ev_clr != '0 && ev_set == '0) |=> (s_q.ris & $past(ev_clr)) == '0)
        else $error("flags not cleared");

    pos_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && wr && wb_req.adr == qei_pkg::OFS_POS && wb_req.sel == 4'hF)
        |=> s_q.pos == $past(wb_req.dat))
        else $error("position write lost");

    wb_ack_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clk_en && access) |=> wb_rsp.ack ##1 !wb_rsp.ack)
        else $error("bus answer not single cycle");

    cov_index_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        pos_en && idx_rise && s_q.ctrl[qei_pkg::CTRL_RESIDX]);
    cov_timer_c: cover property (@(posedge ref_clk) disable iff (!reset_n) vel_expired);
    cov_dir_c:   cover property (@(posedge ref_clk) disable iff (!reset_n)
        ev_set[qei_pkg::EV_DIR]);
    cov_irq_c:   cover property (@(posedge ref_clk) disable iff (!reset_n) irq);
    cov_error_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
        ev_set[qei_pkg::EV_ERROR]);

endmodule
`default_nettype wire

//--- bench/qei_enc_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// rotary encoder, gray phases or step plus direction
// ------------------------------------------------------------
module qei_enc_model (
    // clock and bench commands
    input  wire logic ref_clk,
    input  wire logic go,
    input  wire logic fwd,
    input  wire logic err,
    input  wire logic clkdir,
    // encoder pins
    output logic      first,
    output logic      second
);
    logic [1:0] ph_q = 2'b00;
    logic       ck_q = 1'b0;

    // one step per command; a fault jumps two phases so both pins move
    always @(posedge ref_clk) begin
        if (go && clkdir) begin
            ck_q <= ~ck_q;
        end else if (go) begin
            ph_q <= ph_q + (err ? 2'd2 : (fwd ? 2'd1 : 2'd3));
        end
    end

    // forward: first pin leads by a quarter cycle
    assign first  = clkdir ? ck_q : ph_q[1] ^ ph_q[0];
    assign second = clkdir ? ~fwd : ph_q[1];
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    // ------------------------------------------------------------
    // stimulus, design and encoder
    // ------------------------------------------------------------
    logic                 ref_clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 go = 1'b0;
    logic                 fwd = 1'b1;
    logic                 err = 1'b0;
    logic                 ckdir = 1'b0;
    logic                 index_in = 1'b0;
    logic                 e_first;
    logic                 e_second;
    logic                 irq;
    logic [31:0]          rdat;
    int                   err_count = 0;
    int                   n_compared = 0;
    int                   cycles = 0;
    qei_pkg::qei_wb_req_t req = '0;
    qei_pkg::qei_wb_rsp_t rsp;

    initial forever #12.5 ref_clk = ~ref_clk;

    qei_top dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1), .wb_req(req),
        .wb_rsp(rsp), .encoder_input_first(e_first), .encoder_input_second(e_second),
        .index_in(index_in), .irq(irq));
    qei_enc_model enc_u (.ref_clk(ref_clk), .go(go), .fwd(fwd), .err(err), .clkdir(ckdir),
        .first(e_first), .second(e_second));

    task automatic summarize();
        if (err_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hang guard, far above the several hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // classic cycle; request held until the acking edge
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
        @(posedge ref_clk);
        while (rsp.ack !== 1'b1) @(posedge ref_clk);
        rdat = rsp.dat;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
    endtask

    task automatic rc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, '0);
        cmp(rdat & m, e);
    endtask

    // one go pulse per step, then let the two-cycle pin latency settle
    task automatic mv(input logic f, input int n, input logic e);
        repeat (n) begin
            @(posedge ref_clk);
            go  <= 1'b1;
            fwd <= f;
            err <= e;
            @(posedge ref_clk);
            go <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask

    task automatic pulse_index();
        @(posedge ref_clk);
        index_in <= 1'b1;
        repeat (2) @(posedge ref_clk);
        index_in <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic t_reset();
        rc(qei_pkg::OFS_CTRL, '1, '0);
        rc(qei_pkg::OFS_MAXPOS, '1, qei_pkg::MAXPOS_RESET);
        rc(qei_pkg::OFS_STATUS, '1, 32'h2);
        rc(6'h2C, '1, '0);
    endtask

    task automatic t_phase();
        wb(1'b1, qei_pkg::OFS_CTRL, 32'h3);
        wb(1'b1, qei_pkg::OFS_POS, '0);
        mv(1'b1, 4, 1'b0);
        rc(qei_pkg::OFS_POS, '1, 32'h4);
        mv(1'b0, 1, 1'b0);
        rc(qei_pkg::OFS_POS, '1, 32'h3);
        rc(qei_pkg::OFS_STATUS, 32'h2, '0);
        rc(qei_pkg::OFS_RIS, 32'h4, 32'h4);
        wb(1'b1, qei_pkg::OFS_ISC, 32'h4);
        rc(qei_pkg::OFS_RIS, 32'h4, '0);
        wb(1'b1, qei_pkg::OFS_CTRL, 32'h1);
        wb(1'b1, qei_pkg::OFS_POS, '0);
        mv(1'b1, 4, 1'b0);
        rc(qei_pkg::OFS_POS, '1, 32'h2);
        wb(1'b1, qei_pkg::OFS_CTRL, 32'h13);
        wb(1'b1, qei_pkg::OFS_POS, 32'hA);
        mv(1'b1, 4, 1'b0);
        rc(qei_pkg::OFS_POS, '1, 32'h6);
        wb(1'b1, qei_pkg::OFS_CTRL, 32'h3);
        wb(1'b1, qei_pkg::OFS_MAXPOS, 32'h64);
        wb(1'b1, qei_pkg::OFS_POS, '0);
        mv(1'b0, 1, 1'b0);
        rc(qei_pkg::OFS_POS, '1, 32'h64);
        mv(1'b1, 1, 1'b0);
        rc(qei_pkg::OFS_POS, '1, '0);
    endtask

    task automatic t_index();
        wb(1'b1, qei_pkg::OFS_CTRL, 32'h7);
        wb(1'b1, qei_pkg::OFS_POS, 32'h32);
        pulse_index();
        rc(qei_pkg::OFS_POS, '1, '0);
        rc(qei_pkg::OFS_RIS, 32'h1, 32'h1);
        mv(1'b0, 2, 1'b0);
        pulse_index();
        rc(qei_pkg::OFS_POS, '1, 32'h64);
        wb(1'b1, qei_pkg::OFS_CTRL, 32'h3);
        wb(1'b1, qei_pkg::OFS_POS, 32'h32);
        pulse_index();
        rc(qei_pkg::OFS_POS, '1, 32'h32);
    endtask

    task automatic t_error();
        wb(1'b1, qei_pkg::OFS_ISC, 32'hF);
        wb(1'b1, qei_pkg::OFS_INTEN, 32'h8);
        mv(1'b1, 1, 1'b1);
        rc(qei_pkg::OFS_STATUS, 32'h1, 32'h1);
        cmp({31'h0, irq}, 32'h1);
        rc(qei_pkg::OFS_ISC, '1, 32'h8);
        wb(1'b1, qei_pkg::OFS_INTEN, '0);
        repeat (2) @(posedge ref_clk);
        cmp({31'h0, irq}, '0);
        wb(1'b1, qei_pkg::OFS_INTEN, 32'h8);
        wb(1'b1, qei_pkg::OFS_ISC, 32'h8);
        repeat (2) @(posedge ref_clk);
        cmp({31'h0, irq}, '0);
        wb(1'b1, qei_pkg::OFS_STATUS, 32'h1);
        rc(qei_pkg::OFS_STATUS, 32'h1, '0);
    endtask

    task automatic t_clkdir();
        wb(1'b1, qei_pkg::OFS_CTRL, '0);
        ckdir <= 1'b1;
        wb(1'b1, qei_pkg::OFS_CTRL, 32'h9);
        wb(1'b1, qei_pkg::OFS_POS, '0);
        mv(1'b1, 3, 1'b0);
        rc(qei_pkg::OFS_POS, '1, 32'h3);
        mv(1'b0, 1, 1'b0);
        rc(qei_pkg::OFS_POS, '1, 32'h2);
        wb(1'b1, qei_pkg::OFS_CTRL, '0);
        ckdir <= 1'b0;
    endtask

    // a 200-cycle period leaves room to step and read before it ends
    task automatic t_velocity();
        wb(1'b1, qei_pkg::OFS_LOAD, 32'hC7);
        wb(1'b1, qei_pkg::OFS_CTRL, 32'h20);
        mv(1'b1, 2, 1'b0);
        rc(qei_pkg::OFS_TIMER, '1, 32'hC7);
        rc(qei_pkg::OFS_COUNT, '1, '0);
        wb(1'b1, qei_pkg::OFS_CTRL, 32'h23);
        mv(1'b1, 5, 1'b0);
        rc(qei_pkg::OFS_COUNT, '1, 32'h5);
        repeat (100) begin
            wb(1'b0, qei_pkg::OFS_RIS, '0);
            if (rdat[qei_pkg::EV_TIMER] === 1'b1) break;
        end
        cmp(rdat & 32'h2, 32'h2);
        rc(qei_pkg::OFS_VEL, '1, 32'h5);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_phase();
        t_index();
        t_error();
        t_clkdir();
        t_velocity();
        summarize();
    end
endmodule
`default_nettype wire
